// *** msc_core.sv ***
// Purpose: Digital core of a six-axis motion sensor behind its serial pins
// Assumes: Pins are asynchronous to i_clk and sampled through two flops
// Notes:   Sensor values and events arrive from on-chip logic on i_clk
//
// Overview of operation
// - Chip select low picks the four-wire target, high the two-wire target.
// - Two-wire address bit zero follows the address select pin level.
// - The device only answers the host and never starts a transfer.
// - Four-wire reads return data on the separate data output pin.
// - Gyro full scale chosen from four ranges, 250 to 2000 dps.
// - Sample rate programmable 8000 down to 3.9 per second, filter selectable.
// - Accelerometer full scale chosen from 2, 4, 8 or 16 g.
// - Per-axis self-test enables sit in registers 27 and 28.
// - Clock source is the oscillator alone or automatic best choice.
// - Sensor data registers hold latest results, read-only, readable any time.
// - A 512-byte FIFO stores the data groups the select register picks.
// - The FIFO byte counter always shows bytes held, host-readable.
// - The FIFO data register supports burst reads in one transfer.
// - FIFO reads keep working in duty-cycled accelerometer mode.
// - A config register sets pin polarity, pin type, latching and clearing.
// - Clock lock, new data, accel events and FIFO overflow raise interrupts.
// - An interrupt status register shows pending conditions.
// - Interrupt pin drives push-pull or open-drain.
// - Frame sync input state can be stored in the FIFO.
// - Temperature readable from data registers and from the FIFO.
// - Two-wire address upper six bits fixed, last bit from the pin.
// - Accepts two-wire at 400 kHz and four-wire at 8 MHz.
module msc_core import msc_pkg::*; #(
   parameter int FAST_CYCLES = FAST_CYC,
   parameter int SLOW_CYCLES = SLOW_CYC
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_scl_sclk,
   input wire logic i_sda_sdi,
   output logic o_sda,
   output logic o_sda_oe,
   input wire logic i_address_select_pin,
   output logic o_address_select_pin,
   output logic o_address_select_pin_oe,
   input wire logic i_cs,
   output logic o_int,
   output logic o_int_oe,
   input wire logic i_frame_sync_input,
   input wire logic i_sample_valid,
   input wire msc_sample_type i_sample,
   input wire logic i_clk_lock,
   input wire logic i_accel_event,
   output msc_cfg_type o_cfg,
   output logic o_convert
);
   msc_core_state_type q_r, q_nxt;
   logic [7:0] mem [FIFO_BYTES];
   logic scl_r, scl_f, start, stop, cs_f, i2c_on;
   logic b_in_valid, b_in_ready, b_out_valid, b_out_ready;
   logic [7:0] b_in_data, b_out_data;
   logic inc, wr, load, pop, rd_clear, lvl, fifo_rst;
   logic [7:0] wdata, rdv;
   logic [7:0] ev;
   logic [6:0] nptr;
   logic [3:0] fb;

   // Register read mux for the byte at the pointer
   function automatic logic [7:0] reg_rd(input msc_core_state_type s,
                                         input logic [7:0] fbyte);
      logic [6:0] bi;
      logic [7:0] v;
      bi = A_DATA_LAST - s.ptr;
      v = 8'h00;
      if (s.ptr == A_RATE_DIV) begin
         v = s.rate_div;
      end else if (s.ptr == A_FILTER) begin
         v = s.filter;
      end else if (s.ptr == A_GYRO_ST) begin
         v = s.gst;
      end else if (s.ptr == A_ACCEL_ST) begin
         v = s.ast;
      end else if (s.ptr == A_FIFO_SEL) begin
         v = s.fifo_sel;
      end else if (s.ptr == A_INT_CFG) begin
         v = s.int_cfg;
      end else if (s.ptr == A_INT_EN) begin
         v = s.int_en;
      end else if (s.ptr == A_INT_STAT) begin
         v = s.int_stat;
      end else if (s.ptr >= A_DATA0 && s.ptr <= A_DATA_LAST) begin
         v = s.data[{bi[3:0], 3'b000} +: 8];
      end else if (s.ptr == A_CTRL) begin
         v = s.ctrl;
      end else if (s.ptr == A_PWR) begin
         v = s.pwr;
      end else if (s.ptr == A_CNT_HI) begin
         v = {6'h00, s.cnt[9:8]};
      end else if (s.ptr == A_CNT_LO) begin
         v = s.cnt[7:0];
      end else if (s.ptr == A_FIFO_DATA) begin
         v = fbyte;
      end
      return v;
   endfunction

   // Pin edges and conditions, from the second and third sample flops
   assign scl_r = q_r.scl_s[1] & ~q_r.scl_s[2];
   assign scl_f = ~q_r.scl_s[1] & q_r.scl_s[2];
   assign start = q_r.scl_s[1] & q_r.scl_s[2] & q_r.sda_s[2] & ~q_r.sda_s[1];
   assign stop = q_r.scl_s[1] & q_r.scl_s[2] & ~q_r.sda_s[2] & q_r.sda_s[1];
   assign cs_f = q_r.cs_s[2] & ~q_r.cs_s[1];
   assign i2c_on = q_r.cs_s[1] & ~q_r.ctrl[F_I2C_DIS];
   assign nptr = (q_r.ptr == A_FIFO_DATA) ? q_r.ptr : q_r.ptr + 7'd1;
   assign fifo_rst = q_r.ctrl[F_FIFO_RST];

   // Frame serialiser: byte index skips groups that are not selected
   assign fb = 4'd13 - q_r.fidx;
   always_comb begin
      if (q_r.fidx < 4'd6) begin
         inc = q_r.fifo_sel[F_SEL_ACCEL];
      end else if (q_r.fidx < 4'd8) begin
         inc = q_r.fifo_sel[F_SEL_TEMP];
      end else if (q_r.fidx < SYNC_IDX) begin
         inc = q_r.fifo_sel[F_SEL_GYRO];
      end else begin
         inc = q_r.fifo_sel[F_SEL_SYNC];
      end
   end
   assign b_in_valid = q_r.fbusy & inc;
   assign b_in_data = (q_r.fidx == SYNC_IDX) ? {7'h00, q_r.frame_sync}
                      : q_r.frame[{fb, 3'b000} +: 8];
   assign b_out_ready = (q_r.cnt != 10'(FIFO_BYTES)) & ~fifo_rst;

   msc_skid2 #(.WIDTH(8)) u_buf (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_in_valid(b_in_valid),
      .o_in_ready(b_in_ready),
      .i_in_data(b_in_data),
      .o_out_valid(b_out_valid),
      .i_out_ready(b_out_ready),
      .o_out_data(b_out_data)
   );

   // FIFO storage, written from the buffer output
   always_ff @(posedge i_clk) begin
      if (b_out_valid && b_out_ready) begin
         mem[q_r.wp] <= b_out_data;
      end
   end
   assign rdv = reg_rd(q_r, mem[q_r.rp]);

   // Next state of the whole core
   always_comb begin
      q_nxt = q_r;
      wr = 1'b0;
      load = 1'b0;
      pop = 1'b0;
      rd_clear = 1'b0;
      ev = 8'h00;
      wdata = q_r.sh;
      q_nxt.scl_s = {q_r.scl_s[1:0], i_scl_sclk};
      q_nxt.sda_s = {q_r.sda_s[1:0], i_sda_sdi};
      q_nxt.cs_s = {q_r.cs_s[1:0], i_cs};
      q_nxt.ad0_s = {q_r.ad0_s[0], i_address_select_pin};
      q_nxt.sync_s = {q_r.sync_s[0], i_frame_sync_input};
      q_nxt.ctrl[F_FIFO_RST] = 1'b0;
      // Serial target engine, answers only what the host clocks
      if (cs_f) begin
         q_nxt.spi = 1'b1;
         q_nxt.st = ST_REG;
         q_nxt.bits = 4'd0;
      end else if (q_r.spi && q_r.cs_s[1]) begin
         q_nxt.spi = 1'b0;
         q_nxt.st = ST_IDLE;
      end else if (!q_r.spi && i2c_on && start) begin
         q_nxt.st = ST_DEV;
         q_nxt.bits = 4'd0;
         q_nxt.flag = 1'b0;
      end else if (!q_r.spi && i2c_on && stop) begin
         q_nxt.st = ST_IDLE;
      end else if (scl_r) begin
         case (q_r.st)
            ST_DEV, ST_REG, ST_WR: begin
               q_nxt.sh = {q_r.sh[6:0], q_r.sda_s[1]};
               q_nxt.bits = q_r.bits + 4'd1;
               if (q_r.bits == 4'd7) begin
                  q_nxt.bits = 4'd0;
                  if (q_r.st == ST_DEV) begin
                     q_nxt.st = ST_IDLE;
                     if (q_nxt.sh[7:1] == {I2C_ADDR_HI, q_r.ad0_s[1]}) begin
                        q_nxt.st = ST_ACK;
                        q_nxt.after = q_nxt.sh[0] ? ST_RD : ST_REG;
                     end
                  end else if (q_r.st == ST_REG) begin
                     q_nxt.ptr = q_nxt.sh[6:0];
                     q_nxt.st = ST_ACK;
                     q_nxt.after = ST_WR;
                     if (q_r.spi) begin
                        q_nxt.st = q_nxt.sh[7] ? ST_RD : ST_WR;
                        q_nxt.bits = q_nxt.sh[7] ? 4'd8 : 4'd0;
                     end
                  end else begin
                     wr = 1'b1;
                     wdata = q_nxt.sh;
                     q_nxt.ptr = nptr;
                     q_nxt.st = q_r.spi ? ST_WR : ST_ACK;
                     q_nxt.after = ST_WR;
                  end
               end
            end
            ST_RD: q_nxt.bits = q_r.bits + 4'd1;
            ST_MACK: begin
               if (q_r.sda_s[1]) begin
                  q_nxt.st = ST_IDLE;
               end else begin
                  q_nxt.flag = 1'b1;
               end
            end
            default: ;
         endcase
      end else if (scl_f) begin
         case (q_r.st)
            ST_ACK: begin
               if (!q_r.flag) begin
                  q_nxt.flag = 1'b1;
               end else begin
                  q_nxt.flag = 1'b0;
                  q_nxt.st = q_r.after;
                  load = (q_r.after == ST_RD);
               end
            end
            ST_RD: begin
               if (q_r.bits != 4'd8) begin
                  q_nxt.sh = {q_r.sh[6:0], 1'b0};
               end else if (q_r.spi) begin
                  load = 1'b1;
               end else begin
                  q_nxt.st = ST_MACK;
                  q_nxt.flag = 1'b0;
               end
            end
            ST_MACK: begin
               if (q_r.flag) begin
                  q_nxt.flag = 1'b0;
                  q_nxt.st = ST_RD;
                  load = 1'b1;
               end
            end
            default: ;
         endcase
      end
      // Fetch the next byte to send, FIFO reads pop one byte
      if (load) begin
         q_nxt.sh = rdv;
         q_nxt.bits = 4'd0;
         q_nxt.ptr = nptr;
         pop = (q_r.ptr == A_FIFO_DATA) && (q_r.cnt != 10'd0);
         rd_clear = (q_r.ptr == A_INT_STAT) | q_r.int_cfg[F_INT_ANYRD];
      end
      // Register writes; status, data and count are read-only
      if (wr) begin
         if (q_r.ptr == A_RATE_DIV) begin
            q_nxt.rate_div = wdata;
         end else if (q_r.ptr == A_FILTER) begin
            q_nxt.filter = wdata;
         end else if (q_r.ptr == A_GYRO_ST) begin
            q_nxt.gst = wdata;
         end else if (q_r.ptr == A_ACCEL_ST) begin
            q_nxt.ast = wdata;
         end else if (q_r.ptr == A_FIFO_SEL) begin
            q_nxt.fifo_sel = wdata;
         end else if (q_r.ptr == A_INT_CFG) begin
            q_nxt.int_cfg = wdata;
         end else if (q_r.ptr == A_INT_EN) begin
            q_nxt.int_en = wdata;
         end else if (q_r.ptr == A_CTRL) begin
            q_nxt.ctrl = wdata;
         end else if (q_r.ptr == A_PWR) begin
            q_nxt.pwr = wdata;
         end
      end
      // Sample capture and FIFO frame start
      if (i_sample_valid) begin
         q_nxt.data = i_sample;
         ev[F_EV_DRDY] = 1'b1;
         if (q_r.fifo_sel[3:0] != 4'h0 && !fifo_rst) begin
            if (q_r.fbusy) begin
               ev[F_EV_OVF] = 1'b1;
            end else begin
               q_nxt.frame = i_sample;
               q_nxt.frame_sync = q_r.sync_s[1];
               q_nxt.fbusy = 1'b1;
               q_nxt.fidx = 4'd0;
            end
         end
      end
      if (q_r.fbusy && (!inc || b_in_ready)) begin
         q_nxt.fidx = q_r.fidx + 4'd1;
         q_nxt.fbusy = (q_r.fidx != SYNC_IDX);
      end
      // FIFO pointers and byte counter
      if (b_out_valid && b_out_ready) begin
         q_nxt.wp = q_r.wp + 9'd1;
      end
      if (pop) begin
         q_nxt.rp = q_r.rp + 9'd1;
      end
      q_nxt.cnt = q_r.cnt + {9'd0, b_out_valid & b_out_ready}
                  - {9'd0, pop};
      if (fifo_rst) begin
         q_nxt.wp = 9'd0;
         q_nxt.rp = 9'd0;
         q_nxt.cnt = 10'd0;
         q_nxt.fbusy = 1'b0;
      end
      // Interrupt flags, a new event wins over a clear
      ev[F_EV_LOCK] = i_clk_lock;
      ev[F_EV_ACCEL] = i_accel_event;
      if (rd_clear || (!q_r.int_cfg[F_INT_LATCH] && i_sample_valid)) begin
         q_nxt.int_stat = 8'h00;
      end
      q_nxt.int_stat = q_nxt.int_stat | ev;
      lvl = |(q_nxt.int_stat & q_r.int_en);
      q_nxt.int_pin = q_r.int_cfg[F_INT_LOW] ? ~lvl : lvl;
      q_nxt.int_oe = q_r.int_cfg[F_INT_OD] ? lvl : 1'b1;
      // Sample-rate divider: 8 kHz base with filter bypassed, else 1 kHz
      q_nxt.convert = 1'b0;
      if (q_r.tick >= ((q_r.filter[2:0] == FILTER_BYPASS)
                       ? 17'(FAST_CYCLES - 1) : 17'(SLOW_CYCLES - 1))) begin
         q_nxt.tick = 17'd0;
         q_nxt.dcnt = q_r.dcnt + 8'd1;
         if (q_r.dcnt >= q_r.rate_div) begin
            q_nxt.dcnt = 8'd0;
            q_nxt.convert = 1'b1;
         end
      end else begin
         q_nxt.tick = q_r.tick + 17'd1;
      end
   end

   // State register
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         q_r <= '0;
         q_r.scl_s <= 3'h7;
         q_r.sda_s <= 3'h7;
         q_r.cs_s <= 3'h7;
         q_r.st <= ST_IDLE;
         q_r.after <= ST_IDLE;
         q_r.pwr <= RST_PWR;
         q_r.ctrl <= RST_ZERO;
         q_r.int_oe <= 1'b1;
      end else begin
         q_r <= q_nxt;
      end
   end

   // Pin drivers: open-drain data line, separate output in four-wire mode
   assign o_sda = 1'b0;
   assign o_sda_oe = ~q_r.spi & (((q_r.st == ST_ACK) & q_r.flag)
                     | ((q_r.st == ST_RD) & ~q_r.sh[7]));
   assign o_address_select_pin = q_r.sh[7];
   assign o_address_select_pin_oe = q_r.spi & (q_r.st == ST_RD);
   assign o_int = q_r.int_pin;
   assign o_int_oe = q_r.int_oe;
   assign o_convert = q_r.convert;

   // Configuration towards the analog front end
   assign o_cfg.gyro_fs = q_r.gst[F_FS_LSB +: 2];
   assign o_cfg.accel_fs = q_r.ast[F_FS_LSB +: 2];
   assign o_cfg.rate_div = q_r.rate_div;
   assign o_cfg.filter = q_r.filter[2:0];
   assign o_cfg.gyro_st = q_r.gst[F_ST_LSB +: 3];
   assign o_cfg.accel_st = q_r.ast[F_ST_LSB +: 3];
   assign o_cfg.clk_auto = q_r.pwr[F_CLK_AUTO];
   assign o_cfg.accel_cycle = q_r.pwr[F_ACCEL_CYC];
endmodule // msc_core

// *** msc_core_checker.sv ***
// Purpose: Concurrent checks on the motion sensor core pins
// Assumes: One clock domain, active-low asynchronous reset
// Notes:   Bound to msc_core from the bench top file
module msc_core_checker import msc_pkg::*; #(
   parameter int FAST_CYCLES = FAST_CYC
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_scl_sclk,
   input wire logic i_sda_sdi,
   input wire logic i_cs,
   input wire logic i_sample_valid,
   input wire logic i_clk_lock,
   input wire logic i_accel_event,
   input wire logic o_sda,
   input wire logic o_sda_oe,
   input wire logic o_address_select_pin,
   input wire logic o_address_select_pin_oe,
   input wire logic o_int,
   input wire logic o_int_oe,
   input wire msc_cfg_type o_cfg,
   input wire logic o_convert
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [19:0] gap_r;
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);
   // Cycles since the last conversion request, saturating
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         gap_r <= '1;
      end else if (o_convert) begin
         gap_r <= 20'h00001;
      end else if (gap_r != '1) begin
         gap_r <= gap_r + 20'h00001;
      end
   end
   chk_sdo_idle: assert property (
      i_cs [*5] |-> !o_address_select_pin_oe)
      else $error("data output driven while deselected");
   chk_sda_quiet: assert property (
      !i_cs [*5] |-> !o_sda_oe)
      else $error("two-wire data pulled in four-wire mode");
   chk_sda_target: assert property (
      $rose(o_sda_oe) |-> i_cs && !i_scl_sclk && o_sda == 1'b0)
      else $error("two-wire data pulled outside a low clock");
   chk_cfg_hold: assert property (
      $stable(i_scl_sclk) [*6] |=> $stable(o_cfg))
      else $error("configuration changed without bus clock");
   chk_rst_cfg: assert property (
      $rose(i_nrst) |-> o_cfg == msc_cfg_type'(23'h000002))
      else $error("configuration reset value wrong");
   chk_conv_gap: assert property (
      o_convert |-> gap_r >= FAST_CYCLES)
      else $error("conversion requests too close");
   chk_int_cause: assert property (
      ($stable(i_scl_sclk) && !i_sample_valid && !i_clk_lock
         && !i_accel_event) [*6] |=> $stable({o_int, o_int_oe}))
      else $error("interrupt pin moved without a cause");
   chk_sdo_hold: assert property (
      ($stable(i_scl_sclk) && $stable(i_cs) && $stable(i_sda_sdi)) [*6]
         |=> $stable(o_address_select_pin))
      else $error("data output moved without clock edge");
   cov_read: cover property (o_address_select_pin_oe);
   cov_conv: cover property (o_convert);
   cov_int: cover property ($rose(o_int));
endmodule // msc_core_checker

// *** msc_core_tb_top.sv ***
// Purpose: Self-checking bench for the motion sensor core
// Assumes: Host model on the four-wire bus, short base periods
// Notes:   Data line levels resolved here from both enables
module msc_core_tb_top import msc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, nrst, sclk, sdi, cs, sda, ad, sda_o, sda_oe, sdo, sdo_oe;
   logic irq, irq_oe, frame_sync_input, sv, lock, aev, conv;
   msc_sample_type smp;
   msc_cfg_type cfg;
   int checked, miscompares, n;
   // Open-drain data and strapped-low address select pin
   assign sda = sda_oe ? sda_o : sdi;
   assign ad = sdo_oe ? sdo : 1'b0;
   msc_core #(.FAST_CYCLES(20), .SLOW_CYCLES(40)) dut (
      .i_clk(clk), .i_nrst(nrst), .i_scl_sclk(sclk), .i_sda_sdi(sda),
      .o_sda(sda_o), .o_sda_oe(sda_oe), .i_address_select_pin(ad),
      .o_address_select_pin(sdo), .o_address_select_pin_oe(sdo_oe),
      .i_cs(cs), .o_int(irq), .o_int_oe(irq_oe),
      .i_frame_sync_input(frame_sync_input), .i_sample_valid(sv), .i_sample(smp),
      .i_clk_lock(lock), .i_accel_event(aev), .o_cfg(cfg),
      .o_convert(conv));
   msc_host host (.i_clk(clk), .i_sdo(ad), .i_sdo_oe(sdo_oe),
      .o_sclk(sclk), .o_sdi(sdi), .o_cs(cs));
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rd(input logic [6:0] a, input int k);
      host.xfer({1'b1, a}, k, 8'hFF);
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      host.xfer({1'b0, a}, 1, d);
   endtask
   task automatic pulse(input logic p);
      @(negedge clk);
      sv = ~p;
      lock = p;
      aev = p;
      @(negedge clk);
      sv = 1'b0;
      lock = 1'b0;
      aev = 1'b0;
      repeat (4) @(negedge clk);
   endtask
   task automatic conclude;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic wait_conv;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (conv !== 1'b1 && n < 400);
      if (n >= 400) begin
         miscompares++;
         conclude();
      end
   endtask
   task automatic t_reset;
      wr(A_CTRL, 8'h10);
      rd(A_PWR, 1);
      chk("pwr", RST_PWR, host.rx[0]);
      rd(A_GYRO_ST, 2);
      chk("gyro_st", RST_ZERO, host.rx[0]);
      chk("accel_st", RST_ZERO, host.rx[1]);
      rd(7'h7F, 1);
      chk("unmapped", 8'h00, host.rx[0]);
   endtask
   task automatic t_scale;
      for (int f = 0; f < 4; f++) begin
         wr(A_GYRO_ST, {3'h5, f[1:0], 3'h0});
         wr(A_ACCEL_ST, {3'h2, f[1:0], 3'h0});
         chk("gyro", {3'h5, f[1:0], 3'h0}, {cfg.gyro_st, cfg.gyro_fs, 3'h0});
         chk("accel", {3'h2, f[1:0], 3'h0}, {cfg.accel_st, cfg.accel_fs, 3'h0});
      end
      rd(A_ACCEL_ST, 1);
      chk("accel_rd", 8'h58, host.rx[0]);
   endtask
   task automatic t_rate;
      wr(A_RATE_DIV, 8'h03);
      wr(A_FILTER, 8'h07);
      chk("filter", 8'h07, {5'h00, cfg.filter});
      chk("rate_div", 8'h03, cfg.rate_div);
      wait_conv();
      wait_conv();
      chk("period", 8'h50, n[7:0]);
   endtask
   task automatic t_data;
      smp.accel_x = 16'h1234;
      smp.temp = 16'hA55A;
      pulse(1'b0);
      rd(A_DATA0, 1);
      chk("accel_hi", 8'h12, host.rx[0]);
      wr(7'h41, 8'h00);
      rd(7'h41, 2);
      chk("temp_hi", 8'hA5, host.rx[0]);
      chk("temp_lo", 8'h5A, host.rx[1]);
   endtask
   task automatic t_fifo;
      frame_sync_input = 1'b1;
      wr(A_FIFO_SEL, 8'h05);
      pulse(1'b0);
      rd(A_CNT_HI, 2);
      chk("cnt_hi", 8'h00, host.rx[0]);
      chk("cnt_lo", 8'h03, host.rx[1]);
      rd(A_FIFO_DATA, 3);
      chk("ff_hi", 8'hA5, host.rx[0]);
      chk("ff_lo", 8'h5A, host.rx[1]);
      chk("ff_sync", 8'h01, host.rx[2]);
      rd(A_CNT_LO, 1);
      chk("cnt_end", 8'h00, host.rx[0]);
   endtask
   task automatic t_irq;
      wr(A_INT_EN, 8'h02);
      pulse(1'b1);
      chk("int", 8'h01, {7'h00, irq});
      chk("int_oe", 8'h01, {7'h00, irq_oe});
      rd(A_INT_STAT, 1);
      chk("stat", 8'h06, host.rx[0] & 8'h06);
      pulse(1'b1);
      pulse(1'b0);
      chk("int_clr", 8'h00, {7'h00, irq});
      wr(A_INT_CFG, 8'h40);
      chk("od_off", 8'h00, {7'h00, irq_oe});
      pulse(1'b1);
      chk("od_on", 8'h01, {7'h00, irq_oe});
   endtask
   // Main sequence
   initial begin
      nrst = 1'b0;
      {sv, lock, aev, frame_sync_input} = 4'h0;
      smp = '0;
      checked = 0;
      miscompares = 0;
      repeat (20) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      t_reset();
      t_scale();
      t_rate();
      t_data();
      t_fifo();
      t_irq();
      conclude();
   end
endmodule // msc_core_tb_top

bind msc_core msc_core_checker #(.FAST_CYCLES(FAST_CYCLES)) chk (
   .i_clk, .i_nrst, .i_scl_sclk, .i_sda_sdi, .i_cs, .i_sample_valid,
   .i_clk_lock, .i_accel_event, .o_sda, .o_sda_oe, .o_address_select_pin,
   .o_address_select_pin_oe, .o_int, .o_int_oe, .o_cfg, .o_convert);

// *** msc_host.sv ***
// Purpose: Host controller model driving the four-wire register bus
// Assumes: Mode 3, clock parks high between frames, 160 ns period
// Notes:   Sees the inverse of the data line when it is released
module msc_host (
   input wire logic i_clk,
   input wire logic i_sdo,
   input wire logic i_sdo_oe,
   output logic o_sclk,
   output logic o_sdi,
   output logic o_cs
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] rx [0:15];
   // Idle bus, deselected, pulled-up lines
   initial begin
      o_sclk = 1'b1;
      o_sdi = 1'b1;
      o_cs = 1'b1;
   end
   // One byte, MSB first, data read back on the rising edge
   task automatic byte_x(input logic [7:0] tx, output logic [7:0] rd);
      for (int i = 7; i >= 0; i--) begin
         repeat (8) @(negedge i_clk);
         o_sclk = 1'b0;
         o_sdi = tx[i];
         repeat (8) @(negedge i_clk);
         o_sclk = 1'b1;
         rd[i] = i_sdo_oe ? i_sdo : ~i_sdo;
      end
   endtask
   // Whole transfer: command byte, then n data bytes
   task automatic xfer(input logic [7:0] c, input int n,
                       input logic [7:0] wd);
      logic [7:0] d;
      @(negedge i_clk);
      o_cs = 1'b0;
      byte_x(c, d);
      for (int k = 0; k < n; k++) begin
         byte_x(wd, d);
         rx[k] = d;
      end
      repeat (8) @(negedge i_clk);
      o_cs = 1'b1;
      o_sdi = 1'b1;
      repeat (8) @(negedge i_clk);
   endtask
endmodule // msc_host

// *** msc_pkg.sv ***
// Purpose: Shared constants and types of the motion sensor core
// Assumes: 100 MHz core clock, 7-bit register pointer
// Notes:   Offsets, field positions, reset values and timing live here
package msc_pkg;
   // Register pointers
   localparam logic [6:0] A_RATE_DIV = 7'h19;
   localparam logic [6:0] A_FILTER = 7'h1A;
   localparam logic [6:0] A_GYRO_ST = 7'h1B;
   localparam logic [6:0] A_ACCEL_ST = 7'h1C;
   localparam logic [6:0] A_FIFO_SEL = 7'h23;
   localparam logic [6:0] A_INT_CFG = 7'h37;
   localparam logic [6:0] A_INT_EN = 7'h38;
   localparam logic [6:0] A_INT_STAT = 7'h3A;
   localparam logic [6:0] A_DATA0 = 7'h3B;
   localparam logic [6:0] A_DATA_LAST = 7'h48;
   localparam logic [6:0] A_CTRL = 7'h6A;
   localparam logic [6:0] A_PWR = 7'h6B;
   localparam logic [6:0] A_CNT_HI = 7'h72;
   localparam logic [6:0] A_CNT_LO = 7'h73;
   localparam logic [6:0] A_FIFO_DATA = 7'h74;
   // Fixed upper six bits of the two-wire target address
   localparam logic [5:0] I2C_ADDR_HI = 6'h34;
   // Field positions
   localparam int F_ST_LSB = 5;
   localparam int F_FS_LSB = 3;
   localparam int F_SEL_ACCEL = 3;
   localparam int F_SEL_TEMP = 2;
   localparam int F_SEL_GYRO = 1;
   localparam int F_SEL_SYNC = 0;
   localparam int F_INT_LOW = 7;
   localparam int F_INT_OD = 6;
   localparam int F_INT_LATCH = 5;
   localparam int F_INT_ANYRD = 4;
   localparam int F_EV_DRDY = 0;
   localparam int F_EV_LOCK = 1;
   localparam int F_EV_ACCEL = 2;
   localparam int F_EV_OVF = 4;
   localparam int F_I2C_DIS = 4;
   localparam int F_FIFO_RST = 2;
   localparam int F_CLK_AUTO = 0;
   localparam int F_ACCEL_CYC = 5;
   localparam logic [2:0] FILTER_BYPASS = 3'h7;
   // Reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_PWR = 8'h01;
   // FIFO and frame layout
   localparam int FIFO_BYTES = 512;
   localparam logic [3:0] SYNC_IDX = 4'hE;
   // Timing: 8 kHz and 1 kHz base sample periods
   localparam int CLK_NS = 10;
   localparam int FAST_PERIOD_NS = 125000;
   localparam int SLOW_PERIOD_NS = 1000000;
   localparam int FAST_CYC = FAST_PERIOD_NS / CLK_NS;
   localparam int SLOW_CYC = SLOW_PERIOD_NS / CLK_NS;

   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_DEV = 7'h02,
      ST_REG = 7'h04,
      ST_WR = 7'h08,
      ST_RD = 7'h10,
      ST_ACK = 7'h20,
      ST_MACK = 7'h40
   } msc_phase_type;

   typedef struct packed {
      logic [15:0] accel_x;
      logic [15:0] accel_y;
      logic [15:0] accel_z;
      logic [15:0] temp;
      logic [15:0] gyro_x;
      logic [15:0] gyro_y;
      logic [15:0] gyro_z;
   } msc_sample_type;

   typedef struct packed {
      logic [1:0] gyro_fs;
      logic [1:0] accel_fs;
      logic [7:0] rate_div;
      logic [2:0] filter;
      logic [2:0] gyro_st;
      logic [2:0] accel_st;
      logic clk_auto;
      logic accel_cycle;
   } msc_cfg_type;

   typedef struct packed {
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic [2:0] cs_s;
      logic [1:0] ad0_s;
      logic [1:0] sync_s;
      msc_phase_type st;
      msc_phase_type after;
      logic [3:0] bits;
      logic [7:0] sh;
      logic [6:0] ptr;
      logic spi;
      logic flag;
      logic [7:0] rate_div;
      logic [7:0] filter;
      logic [7:0] gst;
      logic [7:0] ast;
      logic [7:0] fifo_sel;
      logic [7:0] int_cfg;
      logic [7:0] int_en;
      logic [7:0] int_stat;
      logic [7:0] ctrl;
      logic [7:0] pwr;
      msc_sample_type data;
      msc_sample_type frame;
      logic frame_sync;
      logic [3:0] fidx;
      logic fbusy;
      logic [8:0] wp;
      logic [8:0] rp;
      logic [9:0] cnt;
      logic [16:0] tick;
      logic [7:0] dcnt;
      logic convert;
      logic int_pin;
      logic int_oe;
   } msc_core_state_type;
endpackage

// *** msc_skid2.sv ***
// Purpose: Two-entry buffer with valid and ready on both sides
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Output data comes straight from the entry flops
module msc_skid2 import msc_pkg::*; #(
   parameter int WIDTH = 8
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   typedef struct packed {
      logic [1:0][WIDTH-1:0] ent;
      logic [1:0] cnt;
      logic rd;
      logic wr;
   } msc_skid_state_type;

   msc_skid_state_type q_r, q_nxt;
   logic push, pull;

   // Handshakes
   assign o_in_ready = (q_r.cnt != 2'd2);
   assign o_out_valid = (q_r.cnt != 2'd0);
   assign o_out_data = q_r.ent[q_r.rd];
   assign push = i_in_valid & o_in_ready;
   assign pull = o_out_valid & i_out_ready;

   // Next state
   always_comb begin
      q_nxt = q_r;
      if (push) begin
         q_nxt.ent[q_r.wr] = i_in_data;
         q_nxt.wr = ~q_r.wr;
      end
      if (pull) begin
         q_nxt.rd = ~q_r.rd;
      end
      q_nxt.cnt = q_r.cnt + {1'b0, push} - {1'b0, pull};
   end

   // State register
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end
endmodule // msc_skid2
